// *** prx_defines.vh ***
// constants for the phy receive port: register map, field positions,
// strap timing and reset values.
// assumes inclusion by bare name from the design file.
`ifndef PRX_DEFINES_VH
`define PRX_DEFINES_VH

// ==========================================================
// register map (byte addresses)
`define PRX_ADDR_CTRL     4'h0
`define PRX_ADDR_STATUS   4'h4
`define PRX_ADDR_ERRCNT   4'h8

// ==========================================================
// control fields
`define PRX_CTRL_SYM      0
`define PRX_CTRL_RST      1'b0

// ==========================================================
// status fields
`define PRX_ST_MODE_LO    0
`define PRX_ST_MODE_HI    2
`define PRX_ST_IRQSEL     3
`define PRX_ST_CORE_REGULATOR_DISABLE_STRAP     4
`define PRX_ST_RMII       5
`define PRX_ST_CARRIER    6
`define PRX_ST_COLL       7
`define PRX_ST_SPEED      8
`define PRX_ST_DONE       9

// ==========================================================
// strap capture and frame delimiter
`define PRX_STRAP_WAIT    2'h3
`define PRX_SFD_WIRE      8'hab
`define PRX_ERRCNT_W      16

`endif

// *** prx_rx_port.v ***
// receive side of the phy's mii/rmii port toward the mac, with the
// reset-time straps that share those pins and an avalon-mm slave.
// assumes the phy core signals and the link clock come from another
// clock domain, and that the bench resolves each shared pin from its enable.
`timescale 1ns/1ps
`default_nettype none
`include "prx_defines.vh"

module prx_rx_port #(
	parameter ERRCNT_W = `PRX_ERRCNT_W
) (
	input  wire        i_clk,
	input  wire        i_rst_b,
	// phy core side, link clock domain
	input  wire        i_link_clk,
	input  wire [4:0]  i_sym,
	input  wire        i_sym_valid,
	input  wire        i_sym_err,
	input  wire        i_carrier,
	input  wire        i_collision,
	input  wire        i_speed100,
	input  wire        i_full_duplex,
	input  wire        i_tx_active,
	// mac side pins
	input  wire [3:0]  i_rxd_pin,
	output reg  [3:0]  o_rxd,
	output wire [3:0]  o_rxd_oe,
	output reg         o_rx_er,
	output wire        o_rx_er_oe,
	output reg         o_rx_dv,
	output wire        o_rx_dv_oe,
	input  wire        i_rx_clk_pin,
	output reg         o_rx_clk,
	output wire        o_rx_clk_oe,
	input  wire        i_col_pin,
	output reg         o_col_crs_dv,
	output wire        o_col_crs_dv_oe,
	output reg         o_crs,
	output wire        o_crs_oe,
	// latched straps
	output reg  [2:0]  o_mode_strap,
	output reg         o_irq_pin_function_strap,
	output reg         o_core_regulator_disable_strap,
	output reg         o_rmii_sel,
	output reg         o_strap_done,
	// avalon-mm slave
	input  wire [3:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest
);

	// ==========================================================
	// two-flop synchronisers
	localparam SYNC_W = 19;

	wire [SYNC_W-1:0] sync_in;
	reg  [SYNC_W-1:0] sync_1;
	reg  [SYNC_W-1:0] sync_2;

	assign sync_in = {i_col_pin, i_rx_clk_pin, i_rxd_pin, i_tx_active,
		i_full_duplex, i_speed100, i_collision, i_carrier, i_sym_err,
		i_sym_valid, i_sym, i_link_clk};

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			sync_1 <= {SYNC_W{1'b0}};
			sync_2 <= {SYNC_W{1'b0}};
		end else begin
			sync_1 <= sync_in;
			sync_2 <= sync_1;
		end
	end

	wire       lclk_s     = sync_2[0];
	wire [4:0] sym_s      = sync_2[5:1];
	wire       valid_s    = sync_2[6];
	wire       err_s      = sync_2[7];
	wire       carrier_s  = sync_2[8];
	wire       coll_s     = sync_2[9];
	wire       speed_s    = sync_2[10];
	wire       fdx_s      = sync_2[11];
	wire       txact_s    = sync_2[12];
	wire [3:0] rxd_pin_s  = sync_2[16:13];
	wire       rxclk_pin_s = sync_2[17];
	wire       col_pin_s  = sync_2[18];

	// ==========================================================
	// strap capture after reset release
	reg [1:0] strap_cnt;

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			strap_cnt                      <= 2'h0;
			o_strap_done                   <= 1'b0;
			o_mode_strap                   <= 3'h0;
			o_irq_pin_function_strap       <= 1'b1;
			o_core_regulator_disable_strap <= 1'b0;
			o_rmii_sel                     <= 1'b0;
		end else if (!o_strap_done) begin
			if (strap_cnt == `PRX_STRAP_WAIT) begin
				o_strap_done                   <= 1'b1;
				o_mode_strap                   <= rxd_pin_s[2:0];
				o_irq_pin_function_strap       <= rxd_pin_s[3];
				o_core_regulator_disable_strap <= rxclk_pin_s;
				o_rmii_sel                     <= col_pin_s;
			end else begin
				strap_cnt <= strap_cnt + 2'h1;
			end
		end
	end

	// ==========================================================
	// pin drive enables; all released while straps are read
	wire mii_on  = o_strap_done & ~o_rmii_sel;
	wire rmii_on = o_strap_done & o_rmii_sel;

	assign o_rxd_oe        = {mii_on, mii_on, o_strap_done,
		o_strap_done};
	assign o_rx_er_oe      = o_strap_done;
	assign o_rx_dv_oe      = mii_on;
	assign o_rx_clk_oe     = mii_on;
	assign o_col_crs_dv_oe = o_strap_done;
	assign o_crs_oe        = o_strap_done;

	// ==========================================================
	// link clock edges
	reg lclk_q;

	always @(posedge i_clk) begin
		if (!i_rst_b)
			lclk_q <= 1'b0;
		else
			lclk_q <= lclk_s;
	end

	wire lclk_rise = lclk_s & ~lclk_q;
	wire lclk_fall = ~lclk_s & lclk_q;

	// ==========================================================
	// control register and status
	reg                ctrl_sym;
	reg [ERRCNT_W-1:0] err_cnt;
	reg                err_seen;
	reg                in_frame;

	wire sym_mode = ctrl_sym & mii_on;

	// ==========================================================
	// rmii delimiter search and loopback block
	reg  [7:0] sfd_sr;
	reg        sfd_seen;
	wire [7:0] next_sfd_sr;

	// wire order: rxd0 first, then rxd1, of each dibit
	function [7:0] prx_sfd_shift;
		input [7:0] sr;
		input [1:0] dibit;
		begin
			prx_sfd_shift = {sr[5:0], dibit[0], dibit[1]};
		end
	endfunction

	assign next_sfd_sr = prx_sfd_shift(sfd_sr, sym_s[1:0]);

	wire ten_rmii   = rmii_on & ~speed_s;
	wire loop_block = ten_rmii & ~fdx_s & txact_s;
	wire rmii_car   = carrier_s & ~loop_block;

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			sfd_sr   <= 8'h00;
			sfd_seen <= 1'b0;
		end else if (lclk_rise) begin
			if (!rmii_car) begin
				sfd_sr   <= 8'h00;
				sfd_seen <= 1'b0;
			end else if (valid_s && !sfd_seen) begin
				sfd_sr <= next_sfd_sr;
				if (next_sfd_sr == `PRX_SFD_WIRE)
					sfd_seen <= 1'b1;
			end
		end
	end

	// ==========================================================
	// receive outputs
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rxd        <= 4'h0;
			o_rx_er      <= 1'b0;
			o_rx_dv      <= 1'b0;
			o_rx_clk     <= 1'b0;
			o_col_crs_dv <= 1'b0;
			o_crs        <= 1'b0;
		end else begin
			o_rx_clk <= mii_on & lclk_s;
			if (mii_on && lclk_fall) begin
				// mii: updates on falling receive clock
				o_rxd        <= sym_s[3:0];
				o_rx_dv      <= valid_s;
				o_rx_er      <= sym_mode ? sym_s[4] :
					(err_s & valid_s);
				o_col_crs_dv <= coll_s;
				o_crs        <= carrier_s;
			end else if (rmii_on && lclk_rise) begin
				o_rxd[3:2]   <= 2'h0;
				o_rxd[1:0]   <= (rmii_car && valid_s &&
					(speed_s || sfd_seen)) ? sym_s[1:0] : 2'h0;
				o_rx_dv      <= 1'b0;
				o_rx_er      <= err_s & rmii_car;
				o_col_crs_dv <= rmii_car;
				o_crs        <= carrier_s;
			end else if (!o_strap_done) begin
				o_rxd        <= 4'h0;
				o_rx_dv      <= 1'b0;
				o_rx_er      <= 1'b0;
				o_col_crs_dv <= 1'b0;
				o_crs        <= 1'b0;
			end
		end
	end

	// ==========================================================
	// errored frame counter
	wire                frame_on = mii_on ? valid_s : rmii_car;
	wire                err_hit  = err_s & ~sym_mode;
	wire [ERRCNT_W-1:0] next_err_cnt;

	assign next_err_cnt = err_cnt + {{(ERRCNT_W-1){1'b0}}, 1'b1};

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			err_cnt  <= {ERRCNT_W{1'b0}};
			err_seen <= 1'b0;
			in_frame <= 1'b0;
		end else if (o_strap_done) begin
			in_frame <= frame_on;
			// an error in the first cycle of a frame still counts
			if (frame_on && !in_frame) begin
				err_seen <= err_hit;
				if (err_hit)
					err_cnt <= next_err_cnt;
			end else if (frame_on && err_hit && !err_seen) begin
				err_seen <= 1'b1;
				err_cnt  <= next_err_cnt;
			end
		end
	end

	// ==========================================================
	// status word assembly
	function [31:0] prx_status_word;
		input [2:0] mode;
		input       irqsel;
		input       core_regulator_disable_strap;
		input       rmii;
		input       carrier;
		input       coll;
		input       speed;
		input       done;
		begin
			prx_status_word = 32'h0000_0000;
			prx_status_word[`PRX_ST_MODE_HI:`PRX_ST_MODE_LO] = mode;
			prx_status_word[`PRX_ST_IRQSEL]  = irqsel;
			prx_status_word[`PRX_ST_CORE_REGULATOR_DISABLE_STRAP]  = core_regulator_disable_strap;
			prx_status_word[`PRX_ST_RMII]    = rmii;
			prx_status_word[`PRX_ST_CARRIER] = carrier;
			prx_status_word[`PRX_ST_COLL]    = coll;
			prx_status_word[`PRX_ST_SPEED]   = speed;
			prx_status_word[`PRX_ST_DONE]    = done;
		end
	endfunction

	// ==========================================================
	// avalon-mm slave: one wait cycle per access
	reg  bus_ack;
	wire bus_req;
	wire wr_take;

	assign bus_req = i_avs_read | i_avs_write;
	// a write lands only at the edge where waitrequest is low
	assign wr_take = i_avs_write & bus_ack & i_avs_byteenable[0] &
		(i_avs_address == `PRX_ADDR_CTRL);

	assign o_avs_waitrequest = bus_req & ~bus_ack;

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			bus_ack        <= 1'b0;
			ctrl_sym       <= `PRX_CTRL_RST;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
			if (wr_take)
				ctrl_sym <= i_avs_writedata[`PRX_CTRL_SYM];
			if (i_avs_read && !bus_ack) begin
				o_avs_readdata <= 32'h0000_0000;
				case (i_avs_address)
				`PRX_ADDR_CTRL: begin
					o_avs_readdata[`PRX_CTRL_SYM] <= ctrl_sym;
				end
				`PRX_ADDR_STATUS: begin
					o_avs_readdata <= prx_status_word(o_mode_strap,
						o_irq_pin_function_strap,
						o_core_regulator_disable_strap, o_rmii_sel,
						carrier_s, coll_s, speed_s, o_strap_done);
				end
				`PRX_ADDR_ERRCNT: begin
					o_avs_readdata[ERRCNT_W-1:0] <= err_cnt;
				end
				default: begin
					o_avs_readdata <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** prx_chk_assertions.sv ***
// checker: pin and strap relations of the receive port
// assumes a bind onto prx_rx_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
// =====
// assertions
module prx_chk (
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic [3:0] i_rxd_pin,
	input wire logic       i_col_pin,
	input wire logic       i_speed100,
	input wire logic       i_full_duplex,
	input wire logic       i_tx_active,
	input wire logic [3:0] o_rxd,
	input wire logic       o_rx_dv,
	input wire logic       o_rx_clk,
	input wire logic       o_rx_clk_oe,
	input wire logic       o_col_crs_dv,
	input wire logic [2:0] o_mode_strap,
	input wire logic       o_rmii_sel,
	input wire logic       o_strap_done
);
	wire q;
	assign q = o_rmii_sel & ~i_speed100 & ~i_full_duplex & i_tx_active;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	a_rmii_upper_low: assert property (
		o_rmii_sel |-> o_rxd[3:2] == 2'h0) else $error("rmii upper data");
	a_rmii_no_valid: assert property (
		o_rmii_sel |-> !o_rx_dv) else $error("rmii data valid");
	a_rmii_no_clock: assert property (
		o_rmii_sel |-> !o_rx_clk_oe) else $error("rmii clock driven");
	a_mode_latch: assert property (
		$rose(o_strap_done) |->
		{1'b0, o_mode_strap} == ($past(i_rxd_pin) & 4'h7))
		else $error("mode strap wrong");
	a_iface_latch: assert property (
		$rose(o_strap_done) |-> o_rmii_sel == $past(i_col_pin))
		else $error("interface strap wrong");
	a_mii_clk_edge: assert property (
		o_strap_done && $past(o_strap_done) && !o_rmii_sel &&
		$changed({o_rxd, o_rx_dv}) |-> $fell(o_rx_clk))
		else $error("mii data off clock fall");
	a_sfd_hold_low: assert property (
		o_rmii_sel && !i_speed100 && $rose(o_col_crs_dv) |-> o_rxd == 4'h0)
		else $error("data before delimiter");
	a_half_dup_mute: assert property (
		q [*8] ##1 q [*8] |-> !o_col_crs_dv && o_rxd == 4'h0)
		else $error("transmit looped back");
endmodule
bind prx_rx_port prx_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_rxd_pin(i_rxd_pin), .i_col_pin(i_col_pin), .i_speed100(i_speed100),
	.i_full_duplex(i_full_duplex), .i_tx_active(i_tx_active),
	.o_rxd(o_rxd), .o_rx_dv(o_rx_dv), .o_rx_clk(o_rx_clk),
	.o_rx_clk_oe(o_rx_clk_oe), .o_col_crs_dv(o_col_crs_dv),
	.o_mode_strap(o_mode_strap), .o_rmii_sel(o_rmii_sel),
	.o_strap_done(o_strap_done));
`default_nettype wire

// *** prx_mac_model.sv ***
// mac model: resolves shared pins, samples mii receive pins
// assumes strap resistor levels come from the bench
`timescale 1ns/1ps
`default_nettype none
// =====
// mac side
module prx_mac_model (
	input  wire logic [3:0] i_rxd,
	input  wire logic [3:0] i_rxd_oe,
	input  wire logic       i_rx_er,
	input  wire logic       i_rx_dv,
	input  wire logic       i_rx_clk,
	input  wire logic       i_rx_clk_oe,
	input  wire logic       i_col,
	input  wire logic       i_col_oe,
	input  wire logic [5:0] i_strap,
	output wire logic [3:0] o_rxd_pin,
	output wire logic       o_rx_clk_pin,
	output wire logic       o_col_pin,
	output var  logic [4:0] o_cap,
	output var  int         o_cap_n
);
	// released pins settle to their strap level
	assign o_rxd_pin = (i_rxd & i_rxd_oe) | (i_strap[3:0] & ~i_rxd_oe);
	assign o_rx_clk_pin = i_rx_clk_oe ? i_rx_clk : i_strap[4];
	assign o_col_pin = i_col_oe ? i_col : i_strap[5];
	// error and valid are only read here, never driven
	initial o_cap_n = 0;
	// sample on clock rise, error only with valid
	always @(posedge i_rx_clk) if (i_rx_dv) begin
		o_cap <= {i_rx_er, i_rxd};
		o_cap_n <= o_cap_n + 1;
	end
endmodule
`default_nettype wire

// *** prx_rx_port_tb_top.sv ***
// bench: straps, mii frames, rmii 10m receive, bus reads
// assumes the mac model beside the design and the bound checker
`timescale 1ns/1ps
`default_nettype none
// =====
// top
module prx_rx_port_tb_top;
	logic        clk = 0, rst_b = 0, lclk = 0, sv = 0, se = 0, car = 0;
	logic        col = 0, s100 = 1, fd = 1, txa = 0, rd = 0, wr = 0;
	logic        wreq, rer, rdv, rck, rcoe, ccd, ccoe, crs, rpin, cpin;
	logic        irq, rof, rmii, done, ferr = 0;
	logic [4:0]  sym = 0, cap, exq[$];
	logic [5:0]  strap = 0;
	logic [3:0]  adr = 0, rxd, roe, xpin;
	logic [2:0]  mst;
	logic [31:0] wd = 0, rdat;
	logic [7:0]  lf = 8'h53;
	int          capn, mismatches = 0, total_checks = 0, cyc = 0;
	prx_rx_port dut (.i_clk(clk), .i_rst_b(rst_b), .i_link_clk(lclk),
		.i_sym(sym), .i_sym_valid(sv), .i_sym_err(se), .i_carrier(car),
		.i_collision(col), .i_speed100(s100), .i_full_duplex(fd),
		.i_tx_active(txa), .i_rxd_pin(xpin), .o_rxd(rxd), .o_rxd_oe(roe),
		.o_rx_er(rer), .o_rx_er_oe(), .o_rx_dv(rdv), .o_rx_dv_oe(),
		.i_rx_clk_pin(rpin), .o_rx_clk(rck), .o_rx_clk_oe(rcoe),
		.i_col_pin(cpin), .o_col_crs_dv(ccd), .o_col_crs_dv_oe(ccoe),
		.o_crs(crs), .o_crs_oe(), .o_mode_strap(mst),
		.o_irq_pin_function_strap(irq),
		.o_core_regulator_disable_strap(rof), .o_rmii_sel(rmii),
		.o_strap_done(done), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq));
	prx_mac_model mac (.i_rxd(rxd), .i_rxd_oe(roe), .i_rx_er(rer),
		.i_rx_dv(rdv), .i_rx_clk(rck), .i_rx_clk_oe(rcoe), .i_col(ccd),
		.i_col_oe(ccoe), .i_strap(strap), .o_rxd_pin(xpin),
		.o_rx_clk_pin(rpin), .o_col_pin(cpin), .o_cap(cap), .o_cap_n(capn));
	initial forever #5 clk = ~clk;
	initial begin
		#3;
		forever #40 lclk = ~lclk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			end_sim;
		end
	end
	always @(capn) if (capn != 0) begin
		chk("nibble", exq.pop_front(), cap);
	end
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task end_sim;
		if (mismatches == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input int d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		rd <= 0;
		wr <= 0;
		if (n >= 50) chk("bus", 0, 1);
	endtask
	task automatic rst(input logic [5:0] s);
		@(posedge clk);
		strap <= s;
		rst_b <= 0;
		repeat (12) @(posedge clk);
		rst_b <= 1;
		repeat (8) @(posedge clk);
		chk("mode", s[2:0], mst);
		chk("irqsel", s[3], irq);
		chk("core_regulator_disable_strap", s[4], rof);
		chk("rmii", s[5], rmii);
	endtask
	task automatic frame(input logic m);
		repeat (20) begin
			@(posedge lclk);
			lf = lfsr(lf);
			sym <= lf[4:0];
			se <= lf[5];
			if (!m) ferr = ferr | lf[5];
			sv <= 1;
			exq.push_back({m ? lf[4] : lf[5], lf[3:0]});
		end
		@(posedge lclk);
		sv <= 0;
		repeat (40) @(posedge clk);
		chk("left", 0, exq.size());
	endtask
	task automatic rdib(input logic [1:0] d, input int n);
		repeat (n) begin
			@(posedge lclk);
			sym <= {3'h7, d};
			sv <= 1;
			car <= 1;
		end
	endtask
	initial begin
		for (int i = 0; i < 3; i++) begin
			lf = lfsr(lf);
			rst({1'b0, lf[4:0]});
			bus(0, 4'h4, 0);
			chk("status", {23'h1, s100, 3'h0, lf[4:0]}, rdat);
		end
		bus(0, 4'hc, 0);
		chk("unmapped", 0, rdat);
		for (int v = 1; v >= 0; v--) begin
			@(posedge clk);
			car <= v[0];
			col <= v[0];
			repeat (30) @(posedge clk);
			chk("col", v, ccd);
			chk("crs", v, crs);
		end
		frame(0);
		bus(0, 4'h8, 0);
		chk("errcnt", ferr, rdat);
		bus(1, 4'h0, 1);
		bus(0, 4'h0, 0);
		chk("ctrl", 1, rdat);
		frame(1);
		@(posedge clk);
		s100 <= 0;
		fd <= 0;
		rst(6'h28);
		rdib(2'h1, 16);
		chk("preamble", 0, rxd);
		chk("crs_dv", 1, ccd);
		rdib(2'h3, 1);
		rdib(2'h2, 6);
		chk("dibit", 2, rxd);
		@(posedge clk);
		txa <= 1;
		repeat (30) @(posedge clk);
		chk("mute", 0, {ccd, rxd});
		@(posedge clk);
		txa <= 0;
		car <= 0;
		sv <= 0;
		repeat (30) @(posedge clk);
		end_sim;
	end
endmodule
`default_nettype wire
